/* logic/eil_pkg.sv */
package eil_pkg;
    // Register byte offsets (word aligned)
    localparam logic [3:0] ADDR_EXT_INT_STATUS_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
    localparam logic [3:0] ADDR_VECTOR = 4'hc;
    // Status/control field positions
    localparam int BIT_MODE = 0;
    localparam int BIT_IMASK = 1;
    localparam int BIT_ACK = 2;
    localparam int BIT_PEND = 3;
    // Event status bits
    localparam int EV_LATCH = 0;
    localparam int EV_CLEAR = 1;
    localparam int EV_WIDTH = 2;
    // Reset values
    localparam logic [7:0] EXT_INT_STATUS_CONTROL_RESET = 8'h00;
    localparam logic [EV_WIDTH-1:0] EV_RESET = 2'h0;
    // Vector locations of the external interrupt
    localparam logic [15:0] VEC_ADDR_HI = 16'hfffa;
    localparam logic [15:0] VEC_ADDR_LO = 16'hfffb;
    // Bus answers one cycle after the request is seen
    localparam int BUS_WAIT_CYCLES = 1;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_DONE = 2'b01
    } eil_bus_state_type;
endpackage : eil_pkg

/* logic/eil_sync.sv */
`timescale 1ns/1ps
// Two flop synchroniser, resets to the idle (high) pin level
module eil_sync (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;

    // First stage read only by second stage
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= 1'b1;
            sync_out <= 1'b1;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : eil_sync

/* logic/eil_edge.sv */
`timescale 1ns/1ps
// Falling edge detector on the synchronised pin
module eil_edge (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic level_in,
    output logic fall_pulse,
    output logic level_low
);
    logic prev_q;

    // Previous sample for comparison
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= level_in;
        end
    end

    assign fall_pulse = prev_q & ~level_in;
    assign level_low = ~level_in;
endmodule : eil_edge

/* logic/eil_top.sv */
// Added by the designer: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
// How it works
// - A falling edge on the active-low pin sets the request latch.
// - A vector fetch acknowledge clears the request latch.
// - Writing one to the acknowledge bit clears the latch like a vector fetch.
// - Reset clears the latch and edge/level select, even with pin held low.
// - Select one gives edge and level requests; zero gives edge only.
// - Edge-only request holds until acknowledge or reset, cleared regardless of pin.
// - Edge-and-level request holds until acknowledge done and pin high, any order.
// - Latched request reaches the CPU only while the mask bit is clear.
// - A falling edge after acknowledge latches a new request.
// - A taken unmasked request makes the CPU fetch vector at FFFA/FFFB.
// - Pending flag reads one whenever a request is pending, ignoring mask.
// - Acknowledge bit is write-only, reads zero, cleared by reset.
// - In break state, acknowledge writes do nothing unless break clear enable is one.
// - A latch cleared during break stays cleared after break ends.
module eil_top (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic ext_int_pin_n,
    input wire logic vector_fetch,
    input wire logic break_state,
    input wire logic break_clear_enable,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic cpu_int_req,
    output logic [15:0] vector_addr_hi,
    output logic [15:0] vector_addr_lo,
    output logic irq
);
    logic pin_sync;
    logic pin_fall;
    logic pin_low;
    logic latch_q;
    logic mode_q;
    logic mask_q;
    logic ack_pending_q;
    logic [eil_pkg::EV_WIDTH-1:0] ev_status_q;
    logic [eil_pkg::EV_WIDTH-1:0] ev_mask_q;
    eil_pkg::eil_bus_state_type bus_state_q;
    logic bus_req;
    logic wr_take;
    logic rd_take;
    logic sw_ack;
    logic ack_ok;
    logic req_active;
    logic latch_d;
    logic [eil_pkg::EV_WIDTH-1:0] ev_set;

    // Decode a write to a given word offset
    function automatic logic is_wr(input logic [3:0] addr, input logic [3:0] target);
        is_wr = (addr == target);
    endfunction : is_wr

    // Pin synchroniser and edge detection
    eil_sync u_sync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .async_in(ext_int_pin_n),
        .sync_out(pin_sync)
    );

    eil_edge u_edge (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .level_in(pin_sync),
        .fall_pulse(pin_fall),
        .level_low(pin_low)
    );

    // Bus handshake: one wait cycle then answer
    assign bus_req = avs_read | avs_write;
    assign wr_take = avs_write & (bus_state_q == eil_pkg::BUS_DONE);
    assign rd_take = avs_read & (bus_state_q == eil_pkg::BUS_DONE);

    // Handshake state: idle, then one answer cycle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bus_state_q <= eil_pkg::BUS_IDLE;
        end else begin
            unique case (bus_state_q)
                eil_pkg::BUS_IDLE: begin
                    if (bus_req) begin
                        bus_state_q <= eil_pkg::BUS_DONE;
                    end
                end
                eil_pkg::BUS_DONE: begin
                    bus_state_q <= eil_pkg::BUS_IDLE;
                end
                default: begin
                    bus_state_q <= eil_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // Waitrequest registered: low only in the answer cycle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !(bus_req && bus_state_q == eil_pkg::BUS_IDLE);
        end
    end

    // Software acknowledge, gated in break state
    assign sw_ack = wr_take && is_wr(avs_address, eil_pkg::ADDR_EXT_INT_STATUS_CONTROL)
        && avs_writedata[eil_pkg::BIT_ACK];
    assign ack_ok = vector_fetch
        || (sw_ack && (!break_state || break_clear_enable));

    // Request latch next state
    always_comb begin
        latch_d = latch_q;
        if (ack_ok) begin
            latch_d = 1'b0;
        end
        if (pin_fall) begin
            latch_d = 1'b1;
        end
    end

    // Latch holds until cleared; reset drops it regardless of pin
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            latch_q <= 1'b0;
        end else begin
            latch_q <= latch_d;
        end
    end

    // Level mode keeps request while pin low
    assign req_active = latch_q || (mode_q && pin_low);

    // Mode and mask control bits
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mode_q <= eil_pkg::EXT_INT_STATUS_CONTROL_RESET[eil_pkg::BIT_MODE];
            mask_q <= eil_pkg::EXT_INT_STATUS_CONTROL_RESET[eil_pkg::BIT_IMASK];
        end else if (wr_take && is_wr(avs_address, eil_pkg::ADDR_EXT_INT_STATUS_CONTROL)) begin
            mode_q <= avs_writedata[eil_pkg::BIT_MODE];
            mask_q <= avs_writedata[eil_pkg::BIT_IMASK];
        end
    end

    // Ack seen but pin still low (level mode bookkeeping)
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ack_pending_q <= 1'b0;
        end else begin
            ack_pending_q <= (ack_pending_q || ack_ok) && mode_q && pin_low;
        end
    end

    // Request to CPU priority logic and vector location
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cpu_int_req <= 1'b0;
            vector_addr_hi <= 16'h0000;
            vector_addr_lo <= 16'h0000;
        end else begin
            cpu_int_req <= req_active && !mask_q;
            vector_addr_hi <= eil_pkg::VEC_ADDR_HI;
            vector_addr_lo <= eil_pkg::VEC_ADDR_LO;
        end
    end

    // Event status: latch set and latch cleared
    assign ev_set[eil_pkg::EV_LATCH] = pin_fall;
    assign ev_set[eil_pkg::EV_CLEAR] = ack_ok && latch_q;

    // Sticky status, write one to clear
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ev_status_q <= eil_pkg::EV_RESET;
        end else if (wr_take && is_wr(avs_address, eil_pkg::ADDR_IRQ_STATUS)) begin
            // Set wins over write-one-to-clear
            ev_status_q <= (ev_status_q & ~avs_writedata[eil_pkg::EV_WIDTH-1:0]) | ev_set;
        end else begin
            ev_status_q <= ev_status_q | ev_set;
        end
    end

    // Event mask register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ev_mask_q <= eil_pkg::EV_RESET;
        end else if (wr_take && is_wr(avs_address, eil_pkg::ADDR_IRQ_MASK)) begin
            ev_mask_q <= avs_writedata[eil_pkg::EV_WIDTH-1:0];
        end
    end

    // Level interrupt from unmasked sticky bits
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(ev_status_q & ev_mask_q);
        end
    end

    // Read data, registered; ack bit reads zero
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && bus_state_q == eil_pkg::BUS_IDLE) begin
            unique case (avs_address)
                eil_pkg::ADDR_EXT_INT_STATUS_CONTROL: begin
                    avs_readdata <= {28'h0000000, req_active, 1'b0, mask_q, mode_q};
                end
                eil_pkg::ADDR_IRQ_STATUS: begin
                    avs_readdata <= {30'h0, ev_status_q};
                end
                eil_pkg::ADDR_IRQ_MASK: begin
                    avs_readdata <= {30'h0, ev_mask_q};
                end
                eil_pkg::ADDR_VECTOR: begin
                    avs_readdata <= {eil_pkg::VEC_ADDR_HI, eil_pkg::VEC_ADDR_LO};
                end
                default: begin
                    avs_readdata <= eil_pkg::UNMAPPED_READ;
                end
            endcase
        end
    end

    // Request with mask clear reaches CPU one cycle later
    property req_fwd_p;
        @(posedge ref_clk) disable iff (!nrst)
        (req_active && !mask_q) |=> cpu_int_req;
    endproperty
    req_forward_a: assert property (req_fwd_p) else $error("request not forwarded");

    // Mask bit blocks the request at the next edge
    mask_blocks_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        mask_q |=> !cpu_int_req) else $error("masked request forwarded");

    // Latch set and clear
    fall_sets_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        pin_fall |=> latch_q) else $error("falling edge not latched");

    ack_clears_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (ack_ok && !pin_fall) |=> !latch_q) else $error("ack did not clear");

    // Protected break keeps the latch against ack writes
    break_protect_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (latch_q && !vector_fetch && !pin_fall && break_state && !break_clear_enable)
        |=> latch_q) else $error("latch cleared in protected break");

    // Permitted break clear by a software ack
    break_open_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (sw_ack && break_state && break_clear_enable && !pin_fall) |=> !latch_q)
        else $error("permitted break clear ignored");

    // Cleared latch only sets again on a new falling edge
    clear_stays_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!latch_q && !pin_fall) |=> !latch_q) else $error("cleared latch set itself");

    // Low pin in level mode keeps the request up
    sequence level_hold_s;
        mode_q && pin_low && !mask_q;
    endsequence
    level_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        level_hold_s |=> cpu_int_req) else $error("level request dropped");

    // Acknowledged level request waits for the pin, then drops
    sequence level_acked_s;
        ack_pending_q && mode_q && !latch_q && !mask_q;
    endsequence
    level_wait_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        level_acked_s ##0 pin_low |=> cpu_int_req) else $error("acked level dropped early");

    level_release_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        level_acked_s ##0 !pin_low |=> !cpu_int_req) else $error("acked level held");

    // Latch holds until an ack
    edge_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (latch_q && !ack_ok) |=> latch_q) else $error("edge request lost");

    // Edge mode: ack drops the request whatever the pin does
    sequence edge_ack_s;
        (ack_ok && !pin_fall) ##1 !mode_q;
    endsequence
    edge_ack_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        edge_ack_s |=> !cpu_int_req) else $error("edge request kept after ack");

    // Reset drops request, select and mask even with the pin low
    reset_clears_a: assert property (@(posedge ref_clk)
        !nrst |=> (!latch_q && !mode_q && !mask_q && !cpu_int_req))
        else $error("reset left request state");

    // Vector location stands once out of reset
    vector_fixed_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        $past(nrst) |-> (vector_addr_hi == eil_pkg::VEC_ADDR_HI
        && vector_addr_lo == eil_pkg::VEC_ADDR_LO)) else $error("vector location wrong");

    // Ack bit always reads zero
    ack_reads_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (rd_take && avs_address == eil_pkg::ADDR_EXT_INT_STATUS_CONTROL) |-> !avs_readdata[eil_pkg::BIT_ACK])
        else $error("ack bit read as one");

    // Pending flag follows the request, mask or not
    pend_flag_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (avs_read && bus_state_q == eil_pkg::BUS_IDLE && avs_address == eil_pkg::ADDR_EXT_INT_STATUS_CONTROL)
        |=> avs_readdata[eil_pkg::BIT_PEND] == $past(req_active))
        else $error("pending flag wrong");

    // Bus steps: request seen in idle, then one answer cycle
    sequence bus_seen_s;
        bus_req && bus_state_q == eil_pkg::BUS_IDLE;
    endsequence
    sequence bus_answer_s;
        !avs_waitrequest && bus_state_q == eil_pkg::BUS_DONE;
    endsequence
    bus_answer_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        bus_seen_s |=> bus_answer_s) else $error("bus answer missing");

    // Answer lasts one cycle
    bus_single_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        bus_answer_s |=> avs_waitrequest) else $error("answer held too long");

    // No answer without a request
    wait_idle_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !bus_req |=> avs_waitrequest) else $error("answer without request");

    // Sticky events and the level interrupt
    ev_latch_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        pin_fall |=> ev_status_q[eil_pkg::EV_LATCH]) else $error("edge event lost");

    ev_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (ack_ok && latch_q) |=> ev_status_q[eil_pkg::EV_CLEAR]) else $error("ack event lost");

    irq_high_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (|(ev_status_q & ev_mask_q)) |=> irq) else $error("interrupt not raised");

    irq_low_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !(|(ev_status_q & ev_mask_q)) |=> !irq) else $error("interrupt without event");
endmodule : eil_top

/* tb/eil_pin_src.sv */
`timescale 1ns/1ps
// Model of the external source on the active-low interrupt pin
module eil_pin_src (
    input wire logic ref_clk,
    output logic pin_n
);
    // Pull-up keeps the pin high while nobody pulls it down
    initial pin_n = 1'b1;

    // Set the pin level just after a clock edge
    task automatic lvl(input logic v);
        @(posedge ref_clk);
        pin_n <= v;
    endtask : lvl

    // Pull low for n cycles, then let the pull-up restore it
    task automatic pulse(input int n);
        lvl(1'b0);
        repeat (n) @(posedge ref_clk);
        pin_n <= 1'b1;
    endtask : pulse
endmodule : eil_pin_src

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic vector_fetch = 1'b0;
    logic break_state = 1'b0;
    logic break_clear_enable = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic cpu_int_req;
    logic irq;
    logic pin_n;
    logic [15:0] vector_addr_hi;
    logic [15:0] vector_addr_lo;
    logic [31:0] seed = 32'hb0ea;
    logic [31:0] exp_q[$];
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;

    // Clock, 8 ns period
    always #4 ref_clk = ~ref_clk;

    eil_pin_src eil_pin_src_inst (.ref_clk(ref_clk), .pin_n(pin_n));

    eil_top eil_top_inst (
        .ref_clk(ref_clk), .nrst(nrst), .ext_int_pin_n(pin_n),
        .vector_fetch(vector_fetch), .break_state(break_state),
        .break_clear_enable(break_clear_enable), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .cpu_int_req(cpu_int_req), .vector_addr_hi(vector_addr_hi),
        .vector_addr_lo(vector_addr_lo), .irq(irq)
    );

    // Random generator for pulse widths
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_rd

    task automatic chk_sig(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: level %b expected %b", $time, got, exp);
        end
    endtask : chk_sig

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        seed = xs(seed);
        @(posedge ref_clk);
        avs_address <= a;
        // Upper write bits random, no register uses them
        avs_writedata <= wr ? {seed[31:4], d[3:0]} : d;
        avs_write <= wr;
        avs_read <= ~wr;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd

    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : wt

    task automatic pls();
        seed = xs(seed);
        // Break clear enable only matters in break state
        break_clear_enable <= seed[2];
        eil_pin_src_inst.pulse(2 + int'(seed[1:0]));
        wt(5);
    endtask : pls

    task automatic fetch();
        @(posedge ref_clk);
        vector_fetch <= 1'b1;
        @(posedge ref_clk);
        vector_fetch <= 1'b0;
    endtask : fetch

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    // Read data compared at the taking edge against the oldest note
    always @(posedge ref_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            chk_rd(avs_readdata, exp_q.pop_front());
        end
    end

    // Hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc > 20000) begin
            err_total++;
            test_done();
        end
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h0);
        rd(4'h2, 32'h0);
        rd(4'hc, 32'hfffa_fffb);
        $display("test reset done");
        pls();
        chk_sig(cpu_int_req, 1'b1);
        chk_rd({vector_addr_hi, vector_addr_lo}, 32'hfffa_fffb);
        rd(4'h0, 32'h8);
        bus(1'b1, 4'h0, 32'h4);
        rd(4'h0, 32'h0);
        chk_sig(cpu_int_req, 1'b0);
        pls();
        rd(4'h0, 32'h8);
        fetch();
        rd(4'h0, 32'h0);
        eil_pin_src_inst.lvl(1'b0);
        wt(5);
        bus(1'b1, 4'h0, 32'h4);
        rd(4'h0, 32'h0);
        eil_pin_src_inst.lvl(1'b1);
        wt(5);
        rd(4'h0, 32'h0);
        $display("test edge mode done");
        bus(1'b1, 4'h0, 32'h1);
        eil_pin_src_inst.lvl(1'b0);
        wt(5);
        bus(1'b1, 4'h0, 32'h5);
        rd(4'h0, 32'h9);
        chk_sig(cpu_int_req, 1'b1);
        eil_pin_src_inst.lvl(1'b1);
        wt(5);
        rd(4'h0, 32'h1);
        pls();
        rd(4'h0, 32'h9);
        fetch();
        rd(4'h0, 32'h1);
        $display("test level mode done");
        bus(1'b1, 4'h0, 32'h2);
        pls();
        chk_sig(cpu_int_req, 1'b0);
        rd(4'h0, 32'ha);
        bus(1'b1, 4'h0, 32'h0);
        wt(2);
        chk_sig(cpu_int_req, 1'b1);
        bus(1'b1, 4'h0, 32'h4);
        $display("test mask done");
        @(posedge ref_clk);
        break_state <= 1'b1;
        pls();
        break_clear_enable <= 1'b0;
        bus(1'b1, 4'h0, 32'h4);
        rd(4'h0, 32'h8);
        break_clear_enable <= 1'b1;
        bus(1'b1, 4'h0, 32'h4);
        rd(4'h0, 32'h0);
        break_state <= 1'b0;
        break_clear_enable <= 1'b0;
        wt(3);
        rd(4'h0, 32'h0);
        $display("test break done");
        bus(1'b1, 4'h4, 32'h3);
        rd(4'h4, 32'h0);
        pls();
        rd(4'h4, 32'h1);
        chk_sig(irq, 1'b0);
        bus(1'b1, 4'h8, 32'h1);
        wt(2);
        chk_sig(irq, 1'b1);
        bus(1'b1, 4'h8, 32'h2);
        bus(1'b1, 4'h0, 32'h4);
        rd(4'h4, 32'h3);
        chk_sig(irq, 1'b1);
        bus(1'b1, 4'h4, 32'h2);
        wt(2);
        chk_sig(irq, 1'b0);
        rd(4'h8, 32'h2);
        $display("test events done");
        bus(1'b1, 4'h0, 32'h1);
        eil_pin_src_inst.lvl(1'b0);
        wt(5);
        @(posedge ref_clk);
        nrst <= 1'b0;
        wt(2);
        chk_sig(cpu_int_req, 1'b0);
        eil_pin_src_inst.lvl(1'b1);
        wt(4);
        nrst <= 1'b1;
        rd(4'h0, 32'h0);
        rd(4'h8, 32'h0);
        $display("test reset mid-run done");
        test_done();
    end
endmodule : tb_top
